// ---- tb/spi_host_model.sv ----
// Behavioural model of the external serial controller
`timescale 1ns/10ps
module spi_host_model (
   // Pacing clock
   input  wire logic       clk_in,
   // Device drive
   input  wire logic [3:0] dev_io_in,
   input  wire logic [3:0] dev_oe_in,
   // Host pins
   output logic            sclk_out,
   output logic            cs_n_out,
   output logic [3:0]      pin_out
);
   logic [3:0] hv   = 4'hc; // Pause and protect pins held high when unused
   logic [3:0] hoe  = 4'hd;
   logic       cpol = 1'b0;
   logic       flip = 1'b0;

   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
   end
   always @(posedge clk_in) flip <= ~flip;
   // Device wins, else host, else a toggling float
   always_comb
      for (int i = 0; i < 4; i++)
         pin_out[i] = dev_oe_in[i] ? dev_io_in[i] : (hoe[i] ? hv[i] : flip);

   task automatic half();
      repeat (8) @(negedge clk_in);
   endtask
   // Frame start, clock parked at its idle level
   task automatic open(input logic pol);
      cpol = pol;
      sclk_out = pol;
      half();
      cs_n_out = 1'b0;
      half();
   endtask
   task automatic close();
      sclk_out = cpol;
      half();
      cs_n_out = 1'b1;
      half();
   endtask
   // n edges of w lanes, top bits first; rd releases lanes; pins captured on every rising edge
   task automatic shift(input logic [7:0] d, input int w, input int n, input logic rd,
                        output logic [7:0] q);
      q = 8'h00;
      for (int k = 0; k < n; k++) begin
         sclk_out = 1'b0;
         for (int i = 0; i < w; i++) begin
            hv[i] = d[8 - w * (k + 1) + i];
            hoe[i] = !rd;
         end
         half();
         sclk_out = 1'b1;
         for (int i = 0; i < w; i++)
            q[8 - w * (k + 1) + i] = pin_out[i];
         half();
      end
      hoe = 4'hd;
   endtask
endmodule

// ---- tb/stacked_die_fe_props.sv ----
// Concurrent checks on the ports of the serial front end
`timescale 1ns/10ps
module stacked_die_fe_props
   import spi_fe_pkg::*;
#(
   parameter logic [7:0] DIE_IDENTIFIER = 8'h00
) (
   // Watched ports
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic       cs_n_in,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_oe_out,
   input wire logic       prot_wr_in,
   input wire logic [7:0] prot_data_in,
   input wire logic [7:0] prot_reg_out,
   input wire logic       write_block_out,
   input wire logic       prot_lock_out,
   input wire logic       active_out,
   input wire logic       hold_out,
   input wire logic       die_reset_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   property p_reset_vals;
      $fell(rst_in) |-> prot_reg_out == PR_RESET && io_oe_out == 4'h0
         && active_out == (DIE_IDENTIFIER == 8'h00);
   endproperty
   property p_cs_release;
      cs_n_in [*6] |-> io_oe_out == 4'h0;
   endproperty
   property p_write_block;
      (!io_in[2] && prot_reg_out[PR_WPE_BIT]) [*6] |-> write_block_out;
   endproperty
   property p_prot_write;
      prot_wr_in && !prot_lock_out |=> prot_reg_out == $past(prot_data_in);
   endproperty
   property p_lock_keep;
      prot_wr_in && prot_lock_out |=> $stable(prot_reg_out);
   endproperty
   property p_dev_reset;
      die_reset_out |-> ##[0:1] (prot_reg_out == PR_RESET && active_out == (DIE_IDENTIFIER == 8'h00));
   endproperty
   property p_hold_float;
      hold_out [*2] |-> !io_oe_out[1];
   endproperty
   property p_idle_quiet;
      !active_out [*2] |-> io_oe_out == 4'h0;
   endproperty

   a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong");
   a_cs_release: assert property (p_cs_release) else $error("pins driven while deselected");
   a_write_block: assert property (p_write_block) else $error("writes not blocked");
   a_prot_write: assert property (p_prot_write) else $error("protection write lost");
   a_lock_keep: assert property (p_lock_keep) else $error("locked register changed");
   a_dev_reset: assert property (p_dev_reset) else $error("device reset incomplete");
   a_hold_float: assert property (p_hold_float) else $error("output driven in pause");
   a_idle_quiet: assert property (p_idle_quiet) else $error("idle die drives pins");

   c_hold: cover property (hold_out);
   c_block: cover property (write_block_out);
   c_reset: cover property (die_reset_out);
endmodule

bind stacked_die_fe stacked_die_fe_props #(.DIE_IDENTIFIER(DIE_IDENTIFIER)) props_u (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .io_in(io_in),
   .io_oe_out(io_oe_out), .prot_wr_in(prot_wr_in), .prot_data_in(prot_data_in),
   .prot_reg_out(prot_reg_out), .write_block_out(write_block_out),
   .prot_lock_out(prot_lock_out), .active_out(active_out), .hold_out(hold_out),
   .die_reset_out(die_reset_out));

// ---- tb/stacked_die_serial_front_end_bench.sv ----
// Self-checking bench of the serial front end
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("mismatch %s exp %h got %h", nm, exp, got); end end
module stacked_die_serial_front_end_bench;
   import spi_fe_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       prot_wr = 1'b0;
   logic       rx_ready = 1'b1;
   logic       tx_en = 1'b0;
   logic       tx_valid = 1'b0;
   logic [7:0] prot_data = 8'h00;
   logic [7:0] tx_data = 8'h00;
   logic       sclk, cs_n, write_block, prot_lock, rx_valid, tx_ready, active, hold;
   logic       die_reset, overrun;
   logic [3:0] pins, io_out, io_oe;
   logic [7:0] prot_reg, q;
   rx_word_t   rx_word;
   rx_word_t   got[$];
   int         bad_count = 0;
   int         n_compared = 0;
   int         resets = 0;

   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1 && rx_ready) got.push_back(rx_word);
      if (die_reset === 1'b1) resets++;
   end
   always @(negedge sys_clk) if (tx_ready === 1'b1) tx_valid = 1'b0;

   spi_host_model host_u (.clk_in(sys_clk), .dev_io_in(io_out), .dev_oe_in(io_oe),
      .sclk_out(sclk), .cs_n_out(cs_n), .pin_out(pins));
   stacked_die_fe #(.DIE_IDENTIFIER(8'h00)) dut_u (.sys_clk_in(sys_clk), .rst_in(rst), .sclk_in(sclk),
      .cs_n_in(cs_n), .io_in(pins), .io_out(io_out), .io_oe_out(io_oe), .prot_wr_in(prot_wr),
      .prot_data_in(prot_data), .prot_reg_out(prot_reg), .write_block_out(write_block),
      .prot_lock_out(prot_lock), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
      .rx_word_out(rx_word), .tx_en_in(tx_en), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
      .tx_ready_out(tx_ready), .active_out(active), .hold_out(hold),
      .die_reset_out(die_reset), .overrun_out(overrun));

   task automatic wait_clk(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic frame(input logic pol, input logic [63:0] d, input int n);
      host_u.open(pol);
      for (int i = 0; i < n; i++)
         host_u.shift(d[63 - 8 * i -: 8], 1, 8, 1'b0, q);
      host_u.close();
      wait_clk(8);
   endtask
   task automatic wr_prot(input logic [7:0] d);
      prot_data = d;
      prot_wr = 1'b1;
      wait_clk(1);
      prot_wr = 1'b0;
      wait_clk(1);
   endtask
   task automatic summarize();
      if (bad_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic s_reset();
      `CHK("prot_reg", PR_RESET, prot_reg)
      `CHK("active", 1'b1, active)
      `CHK("io_oe", 4'h0, io_oe)
   endtask
   task automatic s_rx();
      for (int m = 0; m < 2; m++) begin
         got.delete();
         host_u.open(m[0]);
         host_u.shift(8'h5a, 1, 4, 1'b0, q);
         host_u.close();
         wait_clk(8);
         frame(m[0], {8'h1f, 8'ha6, 48'h0}, 2);
         `CHK("rx count", 2, got.size())
         `CHK("rx opcode", {1'b1, 8'h1f}, got[0])
         `CHK("rx byte", {1'b0, 8'ha6}, got[1])
      end
   endtask
   task automatic s_fifo();
      got.delete();
      rx_ready = 1'b0;
      frame(1'b0, 64'h0102030405060000, 6);
      `CHK("overrun", 1'b1, overrun)
      `CHK("held", 0, got.size())
      rx_ready = 1'b1;
      wait_clk(10);
      `CHK("drained", 5, got.size())
      `CHK("oldest", {1'b1, 8'h01}, got[0])
   endtask
   task automatic s_prot();
      wr_prot(8'h02);
      `CHK("prot write", 8'h02, prot_reg)
      host_u.hv[2] = 1'b0;
      wait_clk(8);
      `CHK("write block", 1'b1, write_block)
      `CHK("lock", 1'b1, prot_lock)
      wr_prot(8'h00);
      `CHK("locked reg", 8'h02, prot_reg)
      got.delete();
      frame(1'b0, {OP_RD_QUAD_OUT, 56'h0}, 1);
      `CHK("quad refused", 0, got.size())
      host_u.hv[2] = 1'b1;
      wait_clk(8);
      `CHK("block off", 1'b0, write_block)
   endtask
   task automatic s_die();
      frame(1'b0, {OP_DIE_SEL, 8'h01, 48'h0}, 2);
      `CHK("deselected", 1'b0, active)
      got.delete();
      frame(1'b1, {8'h1f, 56'h0}, 1);
      `CHK("idle ignores", 0, got.size())
      frame(1'b1, {OP_DIE_SEL, 8'h00, 48'h0}, 2);
      `CHK("reselected", 1'b1, active)
      frame(1'b0, {OP_DIE_SEL, 8'h01, 48'h0}, 2);
      resets = 0;
      frame(1'b0, {OP_DEV_RST, 56'h0}, 1);
      `CHK("reset pulse", 1, resets)
      `CHK("reset active", 1'b1, active)
      `CHK("reset prot", PR_RESET, prot_reg)
   endtask
   task automatic s_read();
      host_u.open(1'b0);
      host_u.shift(OP_RD_DUAL_OUT, 1, 8, 1'b0, q);
      tx_data = 8'ha5;
      tx_en = 1'b1;
      tx_valid = 1'b1;
      host_u.shift(8'h00, 2, 4, 1'b1, q);
      `CHK("dual data", 8'ha5, q)
      `CHK("dual lanes", 4'h3, io_oe)
      host_u.close();
      tx_en = 1'b0;
      wait_clk(8);
      `CHK("released", 4'h0, io_oe)
   endtask
   task automatic s_quad();
      got.delete();
      host_u.open(1'b0);
      host_u.shift(OP_RD_QUAD_IO, 1, 8, 1'b0, q);
      host_u.shift(8'h30, 4, 1, 1'b0, q);
      `CHK("quad no pause", 1'b0, hold)
      host_u.shift(8'hc0, 4, 1, 1'b0, q);
      host_u.close();
      wait_clk(8);
      `CHK("quad count", 2, got.size())
      `CHK("quad opcode", {1'b1, OP_RD_QUAD_IO}, got[0])
      `CHK("quad byte", {1'b0, 8'h3c}, got[1])
   endtask
   task automatic s_hold();
      got.delete();
      host_u.open(1'b0);
      host_u.hv[3] = 1'b0;
      wait_clk(8);
      `CHK("paused", 1'b1, hold)
      host_u.shift(8'hff, 1, 3, 1'b0, q);
      host_u.hv[3] = 1'b1;
      host_u.shift(8'h1f, 1, 8, 1'b0, q);
      host_u.close();
      wait_clk(8);
      `CHK("pause count", 1, got.size())
      `CHK("after pause", {1'b1, 8'h1f}, got[0])
   endtask

   initial begin
      wait_clk(10);
      rst = 1'b0;
      wait_clk(4);
      s_reset();
      s_rx();
      s_fifo();
      s_prot();
      s_die();
      s_read();
      s_quad();
      s_hold();
      summarize();
   end
   initial begin
      wait_clk(30000);
      bad_count++;
      summarize();
   end
endmodule

// ---- verilog/spi_fe_pkg.sv ----
// Constants and types for the stacked-die serial front end
package spi_fe_pkg;

   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam logic [7:0] OP_DIE_SEL     = 8'hc2;
   localparam logic [7:0] OP_DEV_RST     = 8'hff;
   localparam logic [7:0] OP_RD_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_RD_DUAL_IO  = 8'hbb;
   localparam logic [7:0] OP_RD_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_RD_QUAD_IO  = 8'heb;
   localparam logic [7:0] OP_LD_QUAD     = 8'h32;
   localparam logic [7:0] OP_LD_QUAD_RND = 8'h34;

   // ----------------------------------------
   // Protection register layout
   // ----------------------------------------
   localparam int         PR_SG0_BIT = 0;
   localparam int         PR_WPE_BIT = 1;
   localparam int         PR_BG_LSB  = 3;
   localparam int         PR_SG1_BIT = 7;
   localparam logic [7:0] PR_RESET   = 8'h78;

   // ----------------------------------------
   // Lane widths and counts
   // ----------------------------------------
   localparam logic [3:0] LANE_1     = 4'h1;
   localparam logic [3:0] LANE_2     = 4'h2;
   localparam logic [3:0] LANE_4     = 4'h4;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam int         FIFO_DEPTH = 4;
   localparam int         RX_WIDTH   = 9;

   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } rx_word_t;

   typedef enum logic [2:0] {
      ST_DESEL, ST_OPC, ST_ID, ST_BODY, ST_IGNORE
   } fe_state_t;

endpackage

// ---- verilog/stacked_die_fe.sv ----
// Serial front end of one die of a two-die stacked serial NAND
// ----------------------------------------
// How it works
// - All dies take die-select opcode plus 8-bit identifier; matching die becomes active.
// - Device reset opcode returns every die, active or idle, to power-up state.
// - After power-up or device reset, die zero is the active die.
// - Only the active die drives the bus and accepts instructions other than die-select and device reset.
// - Idle die ignores everything except die-select and device reset.
// - Becoming idle never aborts program or erase already running.
// - Chip select high deselects and releases every output pin.
// - No instruction accepted until chip select has gone high then low.
// - Single-line input sampled on rising clock, output shifted on falling clock.
// - Dual and quad lanes sample on rising edge, drive on falling edge.
// - Clock modes 0 and 3 both supported by edge detection.
// - Dual read opcodes turn serial in and out into data lanes 0 and 1.
// - Protect enable 0: write-protect pin guards protection register only, and only while PR_SG0_BIT is set.
// - Protect enable 1 with pin low blocks every write, program and erase.
// - Protect enable 1 refuses quad reads; pin is a dedicated input.
// - Guard bits with write-protect pin let core protect regions from two blocks.
// - Pause pin low while selected floats output and ignores input and clock.
// - During a quad command the pause pin is data lane 3, no pause.
// - Protect and pause pin functions only in standard and dual operation.
// - Pause starts/ends at pin edge if clock low, else next falling clock.
// - Protect enable sits in protection register bit 1, volatile, resets 0.
// - Quad commands use protect and pause pins as lanes 2 and 3.
// ----------------------------------------
`timescale 1ns/10ps

module fe_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
   logic         do_wr, do_rd;

   assign in_ready_out  = (wp_r - rp_r) != (AW+1)'(D);
   assign out_valid_out = wp_r != rp_r;
   assign out_data_out  = mem_r[rp_r[AW-1:0]];
   assign do_wr         = in_valid_in & in_ready_out;
   assign do_rd         = out_valid_out & out_ready_in;

   always_comb begin
      wp_nxt = do_wr ? wp_r + 1'b1 : wp_r;
      rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
      if (do_wr) begin
         mem_r[wp_r[AW-1:0]] <= in_data_in;
      end
   end
endmodule

module stacked_die_fe
   import spi_fe_pkg::*;
#(
   parameter logic [7:0] DIE_IDENTIFIER = 8'h00
) (
   // Clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   // Serial pins
   input  wire logic                  sclk_in,
   input  wire logic                  cs_n_in,
   input  wire logic [3:0]            io_in,
   output logic [3:0]                 io_out,
   output logic [3:0]                 io_oe_out,
   // Protection
   input  wire logic                  prot_wr_in,
   input  wire logic [7:0]            prot_data_in,
   output logic [7:0]                 prot_reg_out,
   output logic                       write_block_out,
   output logic                       prot_lock_out,
   // Received bytes to core
   output logic                       rx_valid_out,
   input  wire logic                  rx_ready_in,
   output spi_fe_pkg::rx_word_t       rx_word_out,
   // Bytes to send
   input  wire logic                  tx_en_in,
   input  wire logic                  tx_valid_in,
   input  wire logic [7:0]            tx_data_in,
   output logic                       tx_ready_out,
   // Status
   output logic                       active_out,
   output logic                       hold_out,
   output logic                       die_reset_out,
   output logic                       overrun_out
);
   import spi_fe_pkg::*;

   // ----------------------------------------
   // Pin synchronisers and edges
   // ----------------------------------------
   logic [5:0] sy1_r, sy2_r;
   logic       sclk_d_r, cs_d_r;
   logic       cs_s, sclk_s, rise, fall, cs_fall;
   logic       hold_r, hold_nxt, quad_r;
   logic [3:0] io_s;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sy1_r    <= 6'h3f;
         sy2_r    <= 6'h3f;
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b0;
      end else begin
         sy1_r    <= {cs_n_in, sclk_in, io_in};
         sy2_r    <= sy1_r;
         sclk_d_r <= sy2_r[4];
         cs_d_r   <= sy2_r[5];
      end
   end

   assign cs_s    = sy2_r[5];
   assign sclk_s  = sy2_r[4];
   assign io_s    = sy2_r[3:0];
   assign cs_fall = ~cs_s & cs_d_r;
   assign rise    = sclk_s & ~sclk_d_r & ~cs_s & ~hold_r;
   assign fall    = ~sclk_s & sclk_d_r & ~cs_s;

   // ----------------------------------------
   // Pause
   // ----------------------------------------
   always_comb begin
      hold_nxt = hold_r;
      if (cs_s | quad_r) begin
         hold_nxt = 1'b0;
      end else if (~sclk_s | fall) begin
         hold_nxt = ~io_s[3];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         hold_r <= 1'b0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // ----------------------------------------
   // Framing, decode and protection
   // ----------------------------------------
   fe_state_t  st_r, st_nxt;
   logic [7:0] sh_r, sh_nxt, prot_r, prot_nxt;
   logic [3:0] cnt_r, cnt_nxt, in_w_r, in_w_nxt, out_w_r, out_w_nxt;
   logic       quad_nxt, active_r, active_nxt, rst_p_r, rst_p_nxt;
   logic       pend_r, pend_nxt, ovr_r, ovr_nxt, wblk_r, lock_r, lock_nxt;
   rx_word_t   pw_r, pw_nxt;
   logic       fifo_rdy, byte_done, is_quad;

   assign byte_done = rise & ((cnt_r + in_w_r) == BYTE_BITS);
   assign is_quad   = (sh_nxt == OP_RD_QUAD_OUT) | (sh_nxt == OP_RD_QUAD_IO) |
                      (sh_nxt == OP_LD_QUAD) | (sh_nxt == OP_LD_QUAD_RND);

   always_comb begin
      st_nxt     = st_r;
      sh_nxt     = sh_r;
      cnt_nxt    = cnt_r;
      in_w_nxt   = in_w_r;
      out_w_nxt  = out_w_r;
      quad_nxt   = quad_r;
      active_nxt = active_r;
      prot_nxt   = prot_r;
      rst_p_nxt  = 1'b0;
      pend_nxt   = pend_r & ~fifo_rdy;
      pw_nxt     = pw_r;
      ovr_nxt    = ovr_r;
      lock_nxt   = ~io_s[2] & ~quad_r &
                   (prot_r[PR_WPE_BIT] | prot_r[PR_SG0_BIT]);
      if (prot_wr_in & ~lock_r) begin
         prot_nxt = prot_data_in;
      end
      if (rise) begin
         case (in_w_r)
            LANE_1:  sh_nxt = {sh_r[6:0], io_s[0]};
            LANE_2:  sh_nxt = {sh_r[5:0], io_s[1:0]};
            default: sh_nxt = {sh_r[3:0], io_s};
         endcase
         cnt_nxt = byte_done ? 4'h0 : cnt_r + in_w_r;
      end
      case (st_r)
         ST_DESEL: begin
            if (cs_fall) begin
               st_nxt  = ST_OPC;
               cnt_nxt = 4'h0;
               ovr_nxt = 1'b0;
            end
         end
         ST_OPC: begin
            if (byte_done) begin
               st_nxt = ST_IGNORE;
               if (sh_nxt == OP_DIE_SEL) begin
                  st_nxt = ST_ID;
               end else if (sh_nxt == OP_DEV_RST) begin
                  active_nxt = (DIE_IDENTIFIER == 8'h00);
                  prot_nxt   = PR_RESET;
                  rst_p_nxt  = 1'b1;
               end else if (active_r &
                            ~(is_quad & prot_r[PR_WPE_BIT])) begin
                  st_nxt   = ST_BODY;
                  pend_nxt = 1'b1;
                  pw_nxt   = '{first: 1'b1, data: sh_nxt};
                  ovr_nxt  = ovr_r | (pend_r & ~fifo_rdy);
                  quad_nxt = is_quad;
                  if (sh_nxt == OP_RD_DUAL_IO) begin
                     in_w_nxt = LANE_2;
                  end else if (is_quad & (sh_nxt != OP_RD_QUAD_OUT)) begin
                     in_w_nxt = LANE_4;
                  end
                  if ((sh_nxt == OP_RD_DUAL_OUT) | (sh_nxt == OP_RD_DUAL_IO)) begin
                     out_w_nxt = LANE_2;
                  end else if (is_quad) begin
                     out_w_nxt = LANE_4;
                  end
               end
            end
         end
         ST_ID: begin
            if (byte_done) begin
               active_nxt = (sh_nxt == DIE_IDENTIFIER);
               st_nxt     = ST_IGNORE;
            end
         end
         ST_BODY: begin
            if (byte_done) begin
               pend_nxt = 1'b1;
               pw_nxt   = '{first: 1'b0, data: sh_nxt};
               ovr_nxt  = ovr_r | (pend_r & ~fifo_rdy);
            end
         end
         ST_IGNORE: ;
         default: st_nxt = ST_DESEL;
      endcase
      if (cs_s) begin
         st_nxt    = ST_DESEL;
         cnt_nxt   = 4'h0;
         in_w_nxt  = LANE_1;
         out_w_nxt = LANE_1;
         quad_nxt  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_r     <= ST_DESEL;
         sh_r     <= 8'h00;
         cnt_r    <= 4'h0;
         in_w_r   <= LANE_1;
         out_w_r  <= LANE_1;
         quad_r   <= 1'b0;
         active_r <= (DIE_IDENTIFIER == 8'h00);
         prot_r   <= PR_RESET;
         rst_p_r  <= 1'b0;
         pend_r   <= 1'b0;
         pw_r     <= '0;
         ovr_r    <= 1'b0;
         wblk_r   <= 1'b0;
         lock_r   <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         sh_r     <= sh_nxt;
         cnt_r    <= cnt_nxt;
         in_w_r   <= in_w_nxt;
         out_w_r  <= out_w_nxt;
         quad_r   <= quad_nxt;
         active_r <= active_nxt;
         prot_r   <= prot_nxt;
         rst_p_r  <= rst_p_nxt;
         pend_r   <= pend_nxt;
         pw_r     <= pw_nxt;
         ovr_r    <= ovr_nxt;
         wblk_r   <= prot_r[PR_WPE_BIT] & ~io_s[2];
         lock_r   <= lock_nxt;
      end
   end

   // ----------------------------------------
   // Outbound shifter
   // ----------------------------------------
   logic [7:0] txs_r, txs_nxt, byte_out;
   logic [3:0] tcnt_r, tcnt_nxt, iop_r, iop_nxt, oe_r, oe_nxt;
   logic       take_r, take_nxt, drive_ok;

   assign drive_ok = ~cs_s & ~hold_r & active_r & tx_en_in & (st_r == ST_BODY);

   always_comb begin
      txs_nxt  = txs_r;
      tcnt_nxt = tcnt_r;
      iop_nxt  = iop_r;
      oe_nxt   = oe_r;
      take_nxt = 1'b0;
      byte_out = txs_r;
      if (~drive_ok) begin
         oe_nxt = 4'h0;
         if (cs_s) begin
            tcnt_nxt = 4'h0;
         end
      end else if (fall) begin
         if (tcnt_r == 4'h0) begin
            byte_out = tx_valid_in ? tx_data_in : 8'hff;
            take_nxt = tx_valid_in;
         end
         case (out_w_r)
            LANE_1: begin
               iop_nxt = {2'b00, byte_out[7], 1'b0};
               oe_nxt  = 4'h2;
            end
            LANE_2: begin
               iop_nxt = {2'b00, byte_out[7:6]};
               oe_nxt  = 4'h3;
            end
            default: begin
               iop_nxt = byte_out[7:4];
               oe_nxt  = 4'hf;
            end
         endcase
         txs_nxt  = byte_out << out_w_r;
         tcnt_nxt = (tcnt_r + out_w_r) & 4'h7;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         txs_r  <= 8'h00;
         tcnt_r <= 4'h0;
         iop_r  <= 4'h0;
         oe_r   <= 4'h0;
         take_r <= 1'b0;
      end else begin
         txs_r  <= txs_nxt;
         tcnt_r <= tcnt_nxt;
         iop_r  <= iop_nxt;
         oe_r   <= oe_nxt;
         take_r <= take_nxt;
      end
   end

   // ----------------------------------------
   // Receive buffer and outputs
   // ----------------------------------------
   fe_fifo #(.W(RX_WIDTH), .D(FIFO_DEPTH)) u_rx_fifo (
      .clk_in       (sys_clk_in),
      .rst_in       (rst_in),
      .in_valid_in  (pend_r),
      .in_ready_out (fifo_rdy),
      .in_data_in   (pw_r),
      .out_valid_out(rx_valid_out),
      .out_ready_in (rx_ready_in),
      .out_data_out (rx_word_out)
   );

   assign io_out          = iop_r;
   assign io_oe_out       = oe_r;
   assign prot_reg_out    = prot_r;
   assign write_block_out = wblk_r;
   assign prot_lock_out   = lock_r;
   assign tx_ready_out    = take_r;
   assign active_out      = active_r;
   assign hold_out        = hold_r;
   assign die_reset_out   = rst_p_r;
   assign overrun_out     = ovr_r;
endmodule
